// *** design/rect_pins_pkg.sv ***
// constants for the rectifier control and status pin block
package rect_pins_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 12;
  localparam int MV_W   = 16;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_STATE    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SETPOINT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_ADDRESS  = 8'h10;

  // state register fields
  localparam int ST_OUT_ON   = 0;
  localparam int ST_SERIAL   = 1;
  localparam int ST_WP       = 2;
  localparam int ST_LINE_HI  = 3;
  localparam int ST_PFW      = 4;
  localparam int ST_FAULT    = 5;
  localparam int ST_SW_OVR   = 6;
  localparam int ST_ADDR_OK  = 7;
  localparam int ST_SETPT_LO = 16;

  // interrupt event bits
  localparam int EV_W       = 5;
  localparam int EV_OUT_CHG = 0;
  localparam int EV_PFW     = 1;
  localparam int EV_FAULT   = 2;
  localparam int EV_WP      = 3;
  localparam int EV_MODE    = 4;

  // address register fields
  localparam int AD_SLOT_LO = 0;
  localparam int AD_TIER_LO = 4;
  localparam int AD_BUS_LO  = 8;
  localparam int AD_BIT2    = 9;

  // analog thresholds as adc codes of a 0..3.3 V converter
  localparam logic [CODE_W-1:0] TRIM_OPEN_CODE = 12'hE8B; // 3.0 V
  localparam logic [CODE_W-1:0] WP_CODE        = 12'h4D9; // 1.0 V
  localparam int TIER_N = 8;
  localparam int SLOT_N = 4;
  // lower edges of tiers 1..7 (tier 8 is anything below)
  localparam logic [CODE_W-1:0] TIER_EDGE [TIER_N-1] = '{
    12'hE2A, 12'hC2D, 12'hA8F, 12'h86C, 12'h5B3, 12'h356, 12'h18D};
  // lower edges of slots 0..2 on the 10k pull-up divider
  localparam logic [CODE_W-1:0] SLOT_EDGE [SLOT_N-1] = '{
    12'hC00, 12'h800, 12'h400};

  // output setpoint in millivolts
  localparam logic [MV_W-1:0] SETPT_MIN_MV = 16'hABE0; // 44 V
  localparam logic [MV_W-1:0] SETPT_MAX_MV = 16'hE290; // 58 V
  localparam logic [MV_W-1:0] SETPT_DEF_MV = 16'hD2F0; // 54 V
  // 14 V span over the 0..3.0 V trim range, in 1/4096 mV per code
  localparam logic [MV_W-1:0] TRIM_SCALE   = 16'h3C2A;
  localparam int TRIM_SHIFT = 12;

  // timing
  localparam int CLK_MHZ    = 100;
  localparam int DEBOUNCE_US = 1000;
  localparam int SETTLE_US   = 10000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int SETTLE_CYC   = SETTLE_US * CLK_MHZ;
  localparam int CNT_W        = 24;
endpackage

// *** design/rect_pins.sv ***
// control and status pin logic of a rectifier module
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rect_pins
  import rect_pins_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int SETTLE_CYCLES   = SETTLE_CYC
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_b_in,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  output logic                   irq_out,
  // control pins
  input  wire logic              enable_n_in,
  input  wire logic              hotplug_n_in,
  input  wire logic              mode_low_in,
  input  wire logic              selector_reset_n_in,
  // digitised analog pins
  input  wire logic [CODE_W-1:0] trim_code_in,
  input  wire logic [CODE_W-1:0] sense_code_in,
  input  wire logic [CODE_W-1:0] slot_code_in,
  input  wire logic [CODE_W-1:0] tier_code_in,
  // power train status
  input  wire logic              line_high_in,
  input  wire logic              output_good_in,
  input  wire logic              decay_warn_in,
  input  wire logic              fan_fail_in,
  input  wire logic              ot_warn_in,
  input  wire logic              ot_shutdown_in,
  input  wire logic              ov_shutdown_in,
  input  wire logic              internal_fault_in,
  // outputs
  output logic                   output_on_out,
  output logic      [MV_W-1:0]   setpoint_mv_out,
  output logic                   serial_mode_out,
  output logic                   eeprom_wp_out,
  output logic                   selector_reset_out,
  output logic      [1:0]        slot_out,
  output logic      [2:0]        tier_out,
  output logic                   bus_tier_out,
  output logic                   bus_id_bit2_out,
  output logic                   addr_valid_out,
  output logic                   line_rating_out,
  output logic                   pfw_out,
  output logic                   fault_n_out
);

  localparam int NPIN = 3;
  localparam int PIN_EN = 0;
  localparam int PIN_HP = 1;
  localparam int PIN_MD = 2;

  // ---------------- pin synchronisers and debouncers
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_stable;
  assign pin_raw[PIN_EN] = enable_n_in;
  assign pin_raw[PIN_HP] = hotplug_n_in;
  assign pin_raw[PIN_MD] = mode_low_in;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic             meta_q;
      logic             sync_q;
      logic             stab_q;
      logic             stab_d;
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] cnt_d;
      always_comb begin
        stab_d = stab_q;
        cnt_d  = '0;
        if (sync_q != stab_q) begin
          if (cnt_q >= CNT_W'(DEBOUNCE_CYCLES - 1)) begin
            stab_d = sync_q;
          end else begin
            cnt_d = cnt_q + CNT_W'(1);
          end
        end
      end
      // pins idle high: released enable, open hot-plug, open mode pin
      always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          stab_q <= 1'b1;
          cnt_q  <= '0;
        end else begin
          meta_q <= pin_raw[gi];
          sync_q <= meta_q;
          stab_q <= stab_d;
          cnt_q  <= cnt_d;
        end
      end
      assign pin_stable[gi] = stab_q;
    end
  endgenerate

  // ---------------- output gating and mode
  logic serial_mode;
  logic out_on_d;
  logic out_on_q;
  // pulled low through 10k means serial link
  assign serial_mode = ~pin_stable[PIN_MD];
  always_comb begin
    // outside serial mode both pins must hold the output on; in serial mode the hot-plug pin alone
    // hot-plug pin gates in every mode
    out_on_d = ~pin_stable[PIN_HP] & (serial_mode | ~pin_stable[PIN_EN]);
  end

  // ---------------- setpoint
  logic [MV_W-1:0]          trim_mv;
  logic [CODE_W+MV_W-1:0]   trim_prod;
  logic [MV_W-1:0]          sw_mv_q;
  logic [MV_W-1:0]          sw_mv_d;
  logic                     sw_ovr_q;
  logic                     sw_ovr_d;
  logic [MV_W-1:0]          setpt_d;
  logic [MV_W-1:0]          wr_mv;
  logic                     wr_setpt;

  assign trim_prod = trim_code_in * TRIM_SCALE;
  assign wr_setpt  = reg_wr_in && (reg_addr_in == REG_SETPOINT);
  assign wr_mv     = reg_wdata_in[MV_W-1:0];

  always_comb begin
    // linear trim over the adjustment range
    trim_mv = SETPT_MIN_MV + MV_W'(trim_prod >> TRIM_SHIFT);
    // open or high trim gives default
    if (trim_code_in > TRIM_OPEN_CODE) begin
      trim_mv = SETPT_DEF_MV;
    end
    sw_mv_d  = sw_mv_q;
    sw_ovr_d = sw_ovr_q;
    if (wr_setpt) begin
      sw_ovr_d = 1'b1;
      if (wr_mv < SETPT_MIN_MV) begin
        sw_mv_d = SETPT_MIN_MV;
      end else if (wr_mv > SETPT_MAX_MV) begin
        sw_mv_d = SETPT_MAX_MV;
      end else begin
        sw_mv_d = wr_mv;
      end
    end
    setpt_d = sw_ovr_q ? sw_mv_q : trim_mv;
  end

  // ---------------- eeprom lock, selector reset, status pins
  logic wp_d;
  logic sel_rst_d;
  logic fault_d;
  logic pfw_d;
  logic line_d;
  always_comb begin
    // sense above 1 V locks eeprom
    wp_d      = sense_code_in > WP_CODE;
    // grounded reset pin resets the selector
    sel_rst_d = ~selector_reset_n_in;
    fault_d   = fan_fail_in | ot_warn_in | ot_shutdown_in | ov_shutdown_in
              | internal_fault_in;
    // warning drops ahead of output decay
    pfw_d     = out_on_q & output_good_in & ~decay_warn_in;
    line_d    = line_high_in;
  end

  // ---------------- tier and slot capture
  typedef enum logic [1:0] {
    CAP_WAIT = 2'b00,
    CAP_TAKE = 2'b01,
    CAP_HOLD = 2'b11
  } cap_state_t;

  cap_state_t       cap_q;
  cap_state_t       cap_d;
  logic [CNT_W-1:0] settle_q;
  logic [CNT_W-1:0] settle_d;
  logic [2:0]       tier_q;
  logic [2:0]       tier_d;
  logic [1:0]       slot_q;
  logic [1:0]       slot_d;
  logic [2:0]       tier_now;
  logic [1:0]       slot_now;

  always_comb begin
    // count edges the tier voltage lies below
    tier_now = '0;
    for (int i = 0; i < TIER_N - 1; i++) begin
      if (tier_code_in < TIER_EDGE[i]) begin
        tier_now = 3'(i + 1);
      end
    end
    // larger resistor keeps the pin nearer 3.3 V
    slot_now = '0;
    for (int j = 0; j < SLOT_N - 1; j++) begin
      if (slot_code_in < SLOT_EDGE[j]) begin
        slot_now = 2'(j + 1);
      end
    end
  end

  always_comb begin
    cap_d    = cap_q;
    settle_d = settle_q;
    tier_d   = tier_q;
    slot_d   = slot_q;
    // sample once after the settle time
    unique case (cap_q)
      CAP_WAIT: begin
        settle_d = settle_q + CNT_W'(1);
        if (settle_q >= CNT_W'(SETTLE_CYCLES - 1)) begin
          cap_d = CAP_TAKE;
        end
      end
      CAP_TAKE: begin
        tier_d = tier_now;
        slot_d = slot_now;
        cap_d  = CAP_HOLD;
      end
      CAP_HOLD: begin
        cap_d = CAP_HOLD;
      end
      default: begin
        cap_d = CAP_WAIT;
      end
    endcase
  end

  // ---------------- interrupt events
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] irq_stat_q;
  logic [EV_W-1:0] irq_stat_d;
  logic [EV_W-1:0] irq_mask_q;
  logic [EV_W-1:0] irq_mask_d;
  logic            mode_q;
  logic            wr_stat;
  logic            wr_mask;

  assign wr_stat = reg_wr_in && (reg_addr_in == REG_IRQ_STAT);
  assign wr_mask = reg_wr_in && (reg_addr_in == REG_IRQ_MASK);

  always_comb begin
    ev             = '0;
    ev[EV_OUT_CHG] = out_on_d != out_on_q;
    ev[EV_PFW]     = pfw_out & ~pfw_d;
    ev[EV_FAULT]   = fault_d & fault_n_out;
    ev[EV_WP]      = wp_d & ~eeprom_wp_out;
    ev[EV_MODE]    = serial_mode != mode_q;
    // set beats a simultaneous write-one clear
    irq_stat_d = irq_stat_q;
    if (wr_stat) begin
      irq_stat_d = irq_stat_q & ~reg_wdata_in[EV_W-1:0];
    end
    irq_stat_d = irq_stat_d | ev;
    irq_mask_d = wr_mask ? reg_wdata_in[EV_W-1:0] : irq_mask_q;
  end

  // ---------------- read data
  logic [DATA_W-1:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_STATE: begin
          rdata_d[ST_OUT_ON]  = out_on_q;
          rdata_d[ST_SERIAL]  = mode_q;
          rdata_d[ST_WP]      = eeprom_wp_out;
          rdata_d[ST_LINE_HI] = line_rating_out;
          rdata_d[ST_PFW]     = pfw_out;
          rdata_d[ST_FAULT]   = ~fault_n_out;
          rdata_d[ST_SW_OVR]  = sw_ovr_q;
          rdata_d[ST_ADDR_OK] = cap_q == CAP_HOLD;
          rdata_d[ST_SETPT_LO +: MV_W] = setpoint_mv_out;
        end
        REG_IRQ_STAT: rdata_d[EV_W-1:0] = irq_stat_q;
        REG_IRQ_MASK: rdata_d[EV_W-1:0] = irq_mask_q;
        REG_SETPOINT: rdata_d[MV_W-1:0] = sw_mv_q;
        REG_ADDRESS: begin
          rdata_d[AD_SLOT_LO +: 2] = slot_q;
          rdata_d[AD_TIER_LO +: 3] = tier_q;
          rdata_d[AD_BUS_LO]       = tier_q[0];
          rdata_d[AD_BIT2]         = tier_q[0];
        end
        default: rdata_d = '0;
      endcase
    end
  end

  // ---------------- registers
  // reset restores trim control and clears override
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_on_q           <= 1'b0;
      sw_mv_q            <= SETPT_DEF_MV;
      sw_ovr_q           <= 1'b0;
      setpoint_mv_out    <= SETPT_DEF_MV;
      eeprom_wp_out      <= 1'b0;
      selector_reset_out <= 1'b0;
      fault_n_out        <= 1'b1;
      pfw_out            <= 1'b0;
      line_rating_out    <= 1'b0;
      cap_q              <= CAP_WAIT;
      settle_q           <= '0;
      tier_q             <= '0;
      slot_q             <= '0;
      irq_stat_q         <= '0;
      irq_mask_q         <= '0;
      mode_q             <= 1'b0;
      reg_rdata_out      <= '0;
    end else begin
      out_on_q           <= out_on_d;
      sw_mv_q            <= sw_mv_d;
      sw_ovr_q           <= sw_ovr_d;
      setpoint_mv_out    <= setpt_d;
      eeprom_wp_out      <= wp_d;
      selector_reset_out <= sel_rst_d;
      fault_n_out        <= ~fault_d;
      pfw_out            <= pfw_d;
      line_rating_out    <= line_d;
      cap_q              <= cap_d;
      settle_q           <= settle_d;
      tier_q             <= tier_d;
      slot_q             <= slot_d;
      irq_stat_q         <= irq_stat_d;
      irq_mask_q         <= irq_mask_d;
      mode_q             <= serial_mode;
      reg_rdata_out      <= rdata_d;
    end
  end

  assign output_on_out   = out_on_q;
  assign serial_mode_out = mode_q;
  assign slot_out        = slot_q;
  assign tier_out        = tier_q;
  // odd tiers (index even) give bit2 zero
  assign bus_tier_out    = tier_q[0];
  assign bus_id_bit2_out = tier_q[0];
  assign addr_valid_out  = cap_q == CAP_HOLD;
  assign irq_out         = |(irq_stat_q & irq_mask_q);

endmodule
`default_nettype wire

// *** sim/rect_pins_asserts.sv ***
// assertion checker for the rectifier pin block
`timescale 1ns/1ps
`default_nettype none
module rect_pins_asserts
  import rect_pins_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = 4
) (
  input wire logic              clk_sys_in,
  input wire logic              rst_b_in,
  input wire logic              enable_n_in,
  input wire logic              hotplug_n_in,
  input wire logic              mode_low_in,
  input wire logic              selector_reset_n_in,
  input wire logic [CODE_W-1:0] sense_code_in,
  input wire logic              line_high_in,
  input wire logic              decay_warn_in,
  input wire logic              fan_fail_in,
  input wire logic              ot_warn_in,
  input wire logic              ot_shutdown_in,
  input wire logic              ov_shutdown_in,
  input wire logic              internal_fault_in,
  input wire logic              output_on_out,
  input wire logic              eeprom_wp_out,
  input wire logic              selector_reset_out,
  input wire logic [1:0]        slot_out,
  input wire logic [2:0]        tier_out,
  input wire logic              bus_tier_out,
  input wire logic              bus_id_bit2_out,
  input wire logic              addr_valid_out,
  input wire logic              line_rating_out,
  input wire logic              pfw_out,
  input wire logic              fault_n_out
);
  // sync flops, debounce and output register, plus slack
  localparam int LIM = DEBOUNCE_CYCLES + 6;
  int unsigned hp_cnt_q;
  int unsigned en_cnt_q;
  wire logic   any_fault = fan_fail_in | ot_warn_in | ot_shutdown_in | ov_shutdown_in
                           | internal_fault_in;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hp_cnt_q <= 0;
      en_cnt_q <= 0;
    end else begin
      hp_cnt_q <= hotplug_n_in ? hp_cnt_q + 1 : 0;
      en_cnt_q <= (enable_n_in && mode_low_in) ? en_cnt_q + 1 : 0;
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  a_hp_off:
    assert property (hp_cnt_q > LIM |-> !output_on_out)
    else $error("output on with hot-plug pin released");
  a_en_off:
    assert property (en_cnt_q > LIM |-> !output_on_out)
    else $error("output on with enable released");
  a_wp_sense:
    assert property ($past(rst_b_in) |-> eeprom_wp_out == ($past(sense_code_in) > WP_CODE))
    else $error("write protect does not follow sense");
  a_line_copy:
    assert property ($past(rst_b_in) |-> line_rating_out == $past(line_high_in))
    else $error("line rating does not follow line");
  a_fault_any:
    assert property ($past(rst_b_in) |-> fault_n_out == !$past(any_fault))
    else $error("fault pin does not follow faults");
  a_sel_reset:
    assert property (!selector_reset_n_in |=> selector_reset_out)
    else $error("selector reset not passed on");
  a_pfw_drop:
    assert property (decay_warn_in |=> !pfw_out)
    else $error("loss warning high while decay imminent");
  a_addr_held:
    assert property (addr_valid_out && $past(addr_valid_out) |-> $stable(tier_out)
                     && $stable(slot_out))
    else $error("captured address changed");
  a_bit2_fold:
    assert property (addr_valid_out |->
                     bus_id_bit2_out == (tier_out inside {3'h1, 3'h3, 3'h5, 3'h7})
                     && bus_tier_out == bus_id_bit2_out)
    else $error("bus tier fold wrong");

  c_out_on: cover property ($rose(output_on_out));
  c_pfw_low: cover property ($fell(pfw_out));
  c_addr_cap: cover property ($rose(addr_valid_out));
endmodule

bind rect_pins rect_pins_asserts #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_rect_pins_asserts (
  .clk_sys_in, .rst_b_in, .enable_n_in, .hotplug_n_in, .mode_low_in, .selector_reset_n_in,
  .sense_code_in, .line_high_in, .decay_warn_in, .fan_fail_in, .ot_warn_in, .ot_shutdown_in,
  .ov_shutdown_in, .internal_fault_in, .output_on_out, .eeprom_wp_out, .selector_reset_out,
  .slot_out, .tier_out, .bus_tier_out, .bus_id_bit2_out, .addr_valid_out, .line_rating_out,
  .pfw_out, .fault_n_out);
`default_nettype wire

// *** sim/shelf_ctrl_model.sv ***
// shelf controller model driving the rectifier's control pins
`timescale 1ns/1ps
`default_nettype none
module shelf_ctrl_model (
  input  wire logic clk_sys_in,
  input  wire logic want_on_in,
  input  wire logic seated_in,
  input  wire logic serial_in,
  input  wire logic sel_reset_in,
  output logic      enable_n_out,
  output logic      hotplug_n_out,
  output logic      mode_low_out,
  output logic      selector_reset_n_out
);
  // pins start released, as on a unit not yet inserted
  initial begin
    enable_n_out = 1'b1;
    hotplug_n_out = 1'b1;
    mode_low_out = 1'b1;
    selector_reset_n_out = 1'b1;
  end
  always @(posedge clk_sys_in) begin
    // enable pulled low to ask for output
    enable_n_out <= !want_on_in;
    // short pin mates last, breaks first
    hotplug_n_out <= !seated_in;
    // pull-down only, never a hard tie
    mode_low_out <= !serial_in;
    selector_reset_n_out <= !sel_reset_in;
  end
endmodule
`default_nettype wire

// *** sim/rect_pins_tb.sv ***
// self-checking bench for the rectifier pin block
`timescale 1ns/1ps
`default_nettype none
module rect_pins_tb;
  import rect_pins_pkg::*;
  localparam int DEB = 4;
  localparam int SETL = 8;
  logic              clk_sys_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic              want_on = 1'b0, seated = 1'b0, serial = 1'b0, selrst = 1'b0;
  logic              line_hi = 1'b0, good = 1'b0, decay = 1'b0;
  logic [4:0]        flt = '0;
  logic [CODE_W-1:0] trim = 12'hFFF, sense = 12'h000, slot = 12'h900, tier = 12'hB00;
  logic              en_n, hp_n, mode_l, sel_n, irq, out_on, ser, wp, sel_o, btier, bit2;
  logic              valid, lrate, pfw, fault_n;
  logic [MV_W-1:0]   setpt;
  logic [1:0]        slot_o;
  logic [2:0]        tier_o;
  logic [CODE_W-1:0] codes [5] = '{12'h000, 12'h800, 12'hE8B, 12'hE8C, 12'hFFF};
  int                miscompares = 0, check_count = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  shelf_ctrl_model i_shelf_ctrl_model (.clk_sys_in, .want_on_in(want_on), .seated_in(seated),
    .serial_in(serial), .sel_reset_in(selrst), .enable_n_out(en_n), .hotplug_n_out(hp_n),
    .mode_low_out(mode_l), .selector_reset_n_out(sel_n));
  rect_pins #(.DEBOUNCE_CYCLES(DEB), .SETTLE_CYCLES(SETL)) i_rect_pins (
    .clk_sys_in, .rst_b_in, .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq), .enable_n_in(en_n),
    .hotplug_n_in(hp_n), .mode_low_in(mode_l), .selector_reset_n_in(sel_n),
    .trim_code_in(trim), .sense_code_in(sense), .slot_code_in(slot), .tier_code_in(tier),
    .line_high_in(line_hi), .output_good_in(good), .decay_warn_in(decay),
    .fan_fail_in(flt[0]), .ot_warn_in(flt[1]), .ot_shutdown_in(flt[2]),
    .ov_shutdown_in(flt[3]), .internal_fault_in(flt[4]), .output_on_out(out_on),
    .setpoint_mv_out(setpt), .serial_mode_out(ser), .eeprom_wp_out(wp),
    .selector_reset_out(sel_o), .slot_out(slot_o), .tier_out(tier_o), .bus_tier_out(btier),
    .bus_id_bit2_out(bit2), .addr_valid_out(valid), .line_rating_out(lrate), .pfw_out(pfw),
    .fault_n_out(fault_n));

  // ends at a falling edge so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(negedge clk_sys_in);
    chk(nm, rdata, e);
  endtask
  function automatic logic [MV_W-1:0] ref_mv(input logic [CODE_W-1:0] c);
    if (c > TRIM_OPEN_CODE) return SETPT_DEF_MV;
    return SETPT_MIN_MV + MV_W'((32'(c) * 32'(TRIM_SCALE)) >> TRIM_SHIFT);
  endfunction
  task automatic results;
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    wt(9);
    chk("setpoint", setpt, SETPT_DEF_MV);
    chk("fault_n", fault_n, 1);
    @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd_reg("irq_mask", REG_IRQ_MASK, 0);
    rd_reg("unmapped", 8'h40, 0);
    foreach (codes[i]) begin
      @(posedge clk_sys_in);
      trim <= codes[i];
      wt(2);
      chk("trim setpoint", setpt, ref_mv(codes[i]));
    end
    chk("addr_valid", valid, 1);
    chk("tier", tier_o, 2);
    chk("slot", slot_o, 1);
    chk("bit2", {btier, bit2}, 0);
    rd_reg("address", REG_ADDRESS, 32'h21);
    @(posedge clk_sys_in);
    tier <= 12'h100;
    seated <= 1'b1;
    want_on <= 1'b1;
    wt(DEB + 8);
    chk("tier held", tier_o, 2);
    chk("out on", out_on, 1);
    chk("irq masked", irq, 0);
    rd_reg("irq_stat", REG_IRQ_STAT, 1);
    wr_reg(REG_IRQ_MASK, 1);
    wt(1);
    chk("irq", irq, 1);
    wr_reg(REG_IRQ_STAT, 1);
    wt(1);
    chk("irq cleared", irq, 0);
    // short enable glitch must not switch off
    @(posedge clk_sys_in);
    want_on <= 1'b0;
    @(posedge clk_sys_in);
    want_on <= 1'b1;
    good <= 1'b1;
    wt(DEB + 8);
    chk("glitch", out_on, 1);
    chk("pfw", pfw, 1);
    @(posedge clk_sys_in);
    decay <= 1'b1;
    wt(1);
    chk("pfw decay", pfw, 0);
    @(posedge clk_sys_in);
    decay <= 1'b0;
    seated <= 1'b0;
    wt(DEB + 8);
    chk("hot-plug off", out_on, 0);
    @(posedge clk_sys_in);
    seated <= 1'b1;
    want_on <= 1'b0;
    serial <= 1'b1;
    wt(DEB + 8);
    chk("serial", ser, 1);
    chk("serial on", out_on, 1);
    @(posedge clk_sys_in);
    serial <= 1'b0;
    wt(DEB + 8);
    chk("enable off", out_on, 0);
    @(posedge clk_sys_in);
    sense <= 12'h4D9;
    line_hi <= 1'b1;
    selrst <= 1'b1;
    wt(2);
    chk("wp low", wp, 0);
    chk("line hi", lrate, 1);
    chk("sel reset", sel_o, 1);
    @(posedge clk_sys_in);
    sense <= 12'h4DA;
    line_hi <= 1'b0;
    wt(2);
    chk("wp high", wp, 1);
    chk("line lo", lrate, 0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys_in);
      flt <= 5'(1 << i);
      wt(2);
      chk("fault", fault_n, 0);
      @(posedge clk_sys_in);
      flt <= '0;
      wt(2);
      chk("no fault", fault_n, 1);
    end
    wr_reg(REG_SETPOINT, 32'h0000FFFF);
    rd_reg("setpoint clamp", REG_SETPOINT, 32'h0000E290);
    wr_reg(REG_SETPOINT, 32'h0000C350);
    @(posedge clk_sys_in);
    trim <= 12'h000;
    wt(3);
    chk("sw setpoint", setpt, 16'hC350);
    // wp, override and capture flags with the software setpoint on top
    rd_reg("state", REG_STATE, 32'hC35000C4);
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    wt(2);
    @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    wt(SETL + 6);
    chk("trim again", setpt, ref_mv(12'h000));
    chk("tier 8", {tier_o, btier, bit2}, 5'h1F);
    results();
  end

  initial begin
    wt(5000);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
